/* psc_map.svh */
// address map constants for the peripheral set/clear register bank
// assumes byte addresses on a 32-bit peripheral bus
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_REGION_BASE 32'hFFD0_0000
`define PSC_WIN_SHIFT 14
`define PSC_AIC_BASE 32'hFFFF_F000
`define PSC_AIC_SHIFT 12
`define PSC_AIC_GAP 32'hFFFF_C000
`define PSC_OFF_SET 14'h0000
`define PSC_OFF_CLR 14'h0004
`define PSC_OFF_READ 14'h0008
`define PSC_RST_VAL 32'h0000_0000
`endif

/* psc_pkg.sv */
// types shared by the set/clear register bank
// assumes nothing of its surroundings
package psc_pkg;
    typedef enum logic [1:0] {
        PSC_ALIAS_NONE = 2'b00,
        PSC_ALIAS_SET = 2'b01,
        PSC_ALIAS_CLR = 2'b10,
        PSC_ALIAS_READ = 2'b11
    } psc_alias_t;
endpackage

/* psc_scr_if.sv */
// strobes and value between decoder and one aliased register
// assumes one clock domain
`timescale 1ns/1ps
interface psc_scr_if #(parameter int W = 32);
    logic set_stb;
    logic clr_stb;
    logic [W-1:0] wdata;
    logic [W-1:0] value;
    modport ctl (output set_stb, output clr_stb, output wdata, input value);
    modport reg_side (input set_stb, input clr_stb, input wdata, output value);
endinterface

/* psc_scr_reg.sv */
// one register with set and clear write ports
// assumes strobes are one-cycle pulses on clk_in
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_scr_reg #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // decoder side
    psc_scr_if.reg_side bus
);
    logic [W-1:0] val_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            val_r <= W'(`PSC_RST_VAL);
        end else if (bus.set_stb) begin
            val_r <= val_r | bus.wdata; // R4 R7
        end else if (bus.clr_stb) begin
            val_r <= val_r & ~bus.wdata; // R5 R7
        end
    end

    assign bus.value = val_r;

    sequence s_set_wr;
        bus.set_stb;
    endsequence
    sequence s_clr_wr;
        bus.clr_stb && !bus.set_stb;
    endsequence

    AST_SET_BITS: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        s_set_wr |=> ((val_r & $past(bus.wdata)) == $past(bus.wdata)))
        else $error("set port left a bit clear");
    AST_CLR_BITS: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        s_clr_wr |=> ((val_r & $past(bus.wdata)) == '0))
        else $error("clear port left a bit set");
    AST_ZERO_KEEPS: assert property (@(posedge clk_in) disable iff (rst_in) // R7
        (bus.set_stb || bus.clr_stb) |=> ((val_r & ~$past(bus.wdata)) == ($past(val_r) & ~$past(bus.wdata))))
        else $error("zero data bit changed a stored bit");
endmodule // psc_scr_reg

/* psc_top.sv */
// window decoder and aliased registers for the peripheral space
// assumes a simple request port from the core: one-cycle rd or wr strobes
//
// How it works
// R1 - 16 Kbyte windows within top 3 Mbyte
// R2 - interrupt controller window only 4 Kbyte
// R3 - base is window's lowest address, offsets upward
// R4 - first location sets stored bits
// R5 - second location clears stored bits
// R6 - third location reads stored value
// R7 - ones act, zeros leave bits unchanged
// R8 - set/clear read zero; read location ignores writes
`timescale 1ns/1ps
`include "psc_map.svh"
module psc_top #(
    parameter int NUM_PERIPH = 8,
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // request port from the core
    input wire logic [31:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [W-1:0] wdata_in,
    // answer to the core
    output logic ack_out,
    output logic err_out,
    output logic [W-1:0] rdata_out,
    // stored values, peripheral 0 in low bits, interrupt controller last
    output logic [(NUM_PERIPH+1)*W-1:0] reg_val_out
);
    localparam int NREG = NUM_PERIPH + 1;
    localparam int IW = $clog2(NREG + 1);

    logic [31:0] rel;
    logic [31:0] win_idx;
    logic in_region;
    logic is_aic;
    logic hit;
    logic [`PSC_WIN_SHIFT-1:0] off;
    logic [IW-1:0] tgt;
    psc_pkg::psc_alias_t alias_sel;
    logic [W-1:0] vals [NREG];
    logic ack_r;
    logic err_r;
    logic [W-1:0] rdata_r;
    logic [W-1:0] rdata_nxt;
    logic [NREG-1:0] set_vec;
    logic [NREG-1:0] clr_vec;

    // window decode
    always_comb begin
        rel = addr_in - `PSC_REGION_BASE;
        win_idx = rel >> `PSC_WIN_SHIFT; // R1 R3
        in_region = (addr_in >= `PSC_REGION_BASE); // R1
        is_aic = ((addr_in >> `PSC_AIC_SHIFT) == (`PSC_AIC_BASE >> `PSC_AIC_SHIFT)); // R2
        hit = 1'b0;
        tgt = '0;
        off = addr_in[`PSC_WIN_SHIFT-1:0]; // R3
        if (is_aic) begin
            hit = 1'b1;
            tgt = IW'(NUM_PERIPH);
            off = '0;
            off[`PSC_AIC_SHIFT-1:0] = addr_in[`PSC_AIC_SHIFT-1:0]; // R2
        end else if (in_region && (win_idx < 32'(NUM_PERIPH))) begin
            hit = 1'b1;
            tgt = IW'(win_idx);
        end
        alias_sel = psc_pkg::PSC_ALIAS_NONE;
        if (hit) begin
            unique case (off)
                `PSC_OFF_SET: alias_sel = psc_pkg::PSC_ALIAS_SET;
                `PSC_OFF_CLR: alias_sel = psc_pkg::PSC_ALIAS_CLR;
                `PSC_OFF_READ: alias_sel = psc_pkg::PSC_ALIAS_READ;
                default: alias_sel = psc_pkg::PSC_ALIAS_NONE;
            endcase
        end
    end

    // aliased registers
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            psc_scr_if #(.W(W)) link ();
            assign link.set_stb = wr_in && (tgt == IW'(gi)) && (alias_sel == psc_pkg::PSC_ALIAS_SET); // R4
            assign link.clr_stb = wr_in && (tgt == IW'(gi)) && (alias_sel == psc_pkg::PSC_ALIAS_CLR); // R5 R8
            assign link.wdata = wdata_in;
            assign set_vec[gi] = link.set_stb;
            assign clr_vec[gi] = link.clr_stb;
            assign vals[gi] = link.value;
            assign reg_val_out[gi*W +: W] = link.value;
            psc_scr_reg #(.W(W)) u_reg (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .bus(link.reg_side)
            );
        end
    endgenerate

    // read data
    always_comb begin
        rdata_nxt = '0; // R8
        if (rd_in && (alias_sel == psc_pkg::PSC_ALIAS_READ)) begin
            rdata_nxt = vals[tgt]; // R6
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_r <= '0;
        end else if (rd_in) begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            ack_r <= rd_in || wr_in;
            err_r <= (rd_in || wr_in) && (alias_sel == psc_pkg::PSC_ALIAS_NONE); // R1 R2
        end
    end

    assign ack_out = ack_r;
    assign err_out = err_r;
    assign rdata_out = rdata_r;

    sequence s_read_alias;
        rd_in && !wr_in && (alias_sel == psc_pkg::PSC_ALIAS_READ);
    endsequence
    sequence s_read_wo;
        rd_in && !wr_in && (alias_sel inside {psc_pkg::PSC_ALIAS_SET, psc_pkg::PSC_ALIAS_CLR});
    endsequence
    sequence s_any_req;
        rd_in || wr_in;
    endsequence
    sequence s_idle;
        !rd_in && !wr_in;
    endsequence
    sequence s_no_read;
        !rd_in;
    endsequence
    sequence s_gap_access;
        (rd_in || wr_in) && (addr_in >= `PSC_AIC_GAP) && (addr_in < `PSC_AIC_BASE);
    endsequence
    sequence s_high_win;
        (rd_in || wr_in) && in_region && !is_aic && (win_idx >= 32'(NUM_PERIPH));
    endsequence
    sequence s_bad_off;
        (rd_in || wr_in) && hit && (alias_sel == psc_pkg::PSC_ALIAS_NONE);
    endsequence
    sequence s_bad_wr;
        wr_in && !rd_in && (alias_sel == psc_pkg::PSC_ALIAS_NONE);
    endsequence
    sequence s_set_req;
        wr_in && !rd_in && (alias_sel == psc_pkg::PSC_ALIAS_SET);
    endsequence
    sequence s_clr_req;
        wr_in && !rd_in && (alias_sel == psc_pkg::PSC_ALIAS_CLR);
    endsequence
    sequence s_aic_read;
        rd_in && !wr_in && (addr_in == (`PSC_AIC_BASE + 32'(`PSC_OFF_READ)));
    endsequence
    sequence s_last_read;
        rd_in && !wr_in
            && (addr_in == (`PSC_REGION_BASE + (32'(NUM_PERIPH - 1) << `PSC_WIN_SHIFT) + 32'(`PSC_OFF_READ)));
    endsequence

    AST_GAP_ERR: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        s_gap_access |=> (ack_out && err_out))
        else $error("address outside 4 Kbyte window accepted");
    AST_LOW_ERR: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        ((rd_in || wr_in) && (addr_in < `PSC_REGION_BASE)) |=> err_out)
        else $error("address below peripheral region accepted");
    AST_BASE_HIT: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        (rd_in && !wr_in && (addr_in == (`PSC_REGION_BASE + (32'h0000_0001 << `PSC_WIN_SHIFT) + 32'(`PSC_OFF_READ))))
        |=> (!err_out && rdata_out == $past(vals[1])))
        else $error("second window base decoded wrongly");
    AST_READ_VAL: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        s_read_alias |=> (rdata_out == $past(vals[tgt]) && ack_out))
        else $error("read location did not return stored value");
    AST_WO_ZERO: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        s_read_wo |=> (rdata_out == '0 && !err_out))
        else $error("set or clear location read nonzero");
    AST_RD_NO_EFFECT: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        (!wr_in) |=> (reg_val_out == $past(reg_val_out)))
        else $error("register changed without a write");
    AST_WR_READ_IGN: assert property (@(posedge clk_in) disable iff (rst_in) // R8
        (wr_in && (alias_sel == psc_pkg::PSC_ALIAS_READ)) |=> (reg_val_out == $past(reg_val_out)))
        else $error("write to read location changed a register");
    AST_IDLE_QUIET: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        s_idle |=> (!ack_out && !err_out))
        else $error("answer without a request");
    AST_ACK_EACH: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        s_any_req |=> ack_out)
        else $error("request not answered in one cycle");
    AST_HIGH_WIN_ERR: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        s_high_win |=> (ack_out && err_out))
        else $error("window above last peripheral accepted");
    AST_BAD_OFF_ERR: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        s_bad_off |=> (ack_out && err_out))
        else $error("unmapped offset accepted");
    AST_BAD_WR_KEEP: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        s_bad_wr |=> (reg_val_out == $past(reg_val_out)))
        else $error("refused write changed a register");
    AST_SET_TGT: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        s_set_req |=> (vals[$past(tgt)] == ($past(vals[tgt]) | $past(wdata_in))))
        else $error("set write gave wrong stored value");
    AST_CLR_TGT: assert property (@(posedge clk_in) disable iff (rst_in) // R5
        s_clr_req |=> (vals[$past(tgt)] == ($past(vals[tgt]) & ~$past(wdata_in))))
        else $error("clear write gave wrong stored value");
    AST_ONE_TARGET: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        $onehot0(set_vec | clr_vec))
        else $error("write strobed more than one register");
    AST_AIC_READ: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        s_aic_read |=> (!err_out && rdata_out == $past(vals[NUM_PERIPH])))
        else $error("interrupt controller read decoded wrongly");
    AST_LAST_WIN: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        s_last_read |=> (!err_out && rdata_out == $past(vals[NUM_PERIPH - 1])))
        else $error("last peripheral window decoded wrongly");
    AST_RDATA_HOLD: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        s_no_read |=> (rdata_out == $past(rdata_out)))
        else $error("read data changed without a read");
endmodule // psc_top

/* psc_core_model.sv */
// core-side request driver for the set/clear register bank
// assumes psc_top answers exactly one cycle after each strobe
`timescale 1ns/1ps
module psc_core_model (
    // clock
    input wire logic clk_in,
    // answer from the bank
    input wire logic ack_in,
    input wire logic err_in,
    input wire logic [31:0] rdata_in,
    // requests to the bank
    output logic [31:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [31:0] wdata_out
);
    initial begin
        addr_out = 32'h0000_0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 32'h0000_0000;
    end
    // one-cycle strobe; answer taken at the edge where ack stands
    task automatic req(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic ack, output logic err, output logic [31:0] rdata);
        addr_out <= a;
        wr_out <= w;
        rd_out <= !w;
        wdata_out <= d;
        @(posedge clk_in);
        addr_out <= ~a;
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        wdata_out <= ~d;
        @(posedge clk_in);
        ack = ack_in;
        err = err_in;
        rdata = rdata_in;
    endtask
endmodule // psc_core_model

/* psc_top_tb.sv */
// self-checking bench for the set/clear register bank
// assumes psc_top with 8 windows and 32-bit words
`timescale 1ns/1ps
module psc_top_tb;
    localparam int NP = 8;
    localparam logic [31:0] BASE = 32'hFFD0_0000;
    localparam logic [31:0] AIC = 32'hFFFF_F000;
    logic clk_in, rst_in, wr, rd, ack, err;
    logic [31:0] addr, wdata, rdata;
    logic [(NP+1)*32-1:0] vals;
    int n_mismatch = 0;
    int n_compared = 0;
    psc_top #(.NUM_PERIPH(NP), .W(32)) dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_in(wr),
        .rd_in(rd), .wdata_in(wdata), .ack_out(ack), .err_out(err), .rdata_out(rdata), .reg_val_out(vals));
    psc_core_model core (.clk_in(clk_in), .ack_in(ack), .err_in(err), .rdata_in(rdata), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one access; read data judged on reads only
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic e_err,
            input logic [31:0] e_rd);
        logic k, e;
        logic [31:0] r;
        core.req(w, a, d, k, e, r);
        chk(k, 1'b1);
        chk(e, e_err);
        if (!w) chk(r, e_rd);
    endtask
    task automatic s_reset;
        for (int i = 0; i <= NP; i++) chk(vals[i*32 +: 32], 32'h0000_0000);
        chk({ack, err}, 2'b00);
        chk(rdata, 32'h0000_0000);
    endtask
    task automatic s_set_clear;
        acc(1'b1, BASE, 32'hA5A5_0F0F, 1'b0, 32'h0);
        acc(1'b0, BASE + 32'h8, 32'h0, 1'b0, 32'hA5A5_0F0F);
        acc(1'b1, BASE, 32'h0000_F0F0, 1'b0, 32'h0);
        acc(1'b1, BASE + 32'h4, 32'h0F0F_0005, 1'b0, 32'h0);
        acc(1'b0, BASE + 32'h8, 32'h0, 1'b0, 32'hA0A0_FFFA);
        acc(1'b1, BASE + 32'h4, 32'hFFFF_FFFF, 1'b0, 32'h0);
        chk(vals[31:0], 32'h0000_0000);
    endtask
    task automatic s_windows;
        for (int i = 0; i < NP; i++) acc(1'b1, BASE + i * 32'h4000, i + 1, 1'b0, 32'h0);
        acc(1'b1, AIC, 32'h8000_0001, 1'b0, 32'h0);
        for (int i = 0; i < NP; i++) begin
            acc(1'b0, BASE + i * 32'h4000 + 32'h8, 32'h0, 1'b0, i + 1);
            chk(vals[i*32 +: 32], i + 1);
        end
        acc(1'b0, AIC + 32'h8, 32'h0, 1'b0, 32'h8000_0001);
        chk(vals[NP*32 +: 32], 32'h8000_0001);
        acc(1'b1, AIC + 32'h4, 32'h8000_0000, 1'b0, 32'h0);
        acc(1'b0, AIC + 32'h8, 32'h0, 1'b0, 32'h0000_0001);
    endtask
    task automatic s_refused;
        acc(1'b0, BASE + 32'h4000, 32'h0, 1'b0, 32'h0);
        acc(1'b0, BASE + 32'h4004, 32'h0, 1'b0, 32'h0);
        acc(1'b1, BASE + 32'h4008, 32'hFFFF_FFFF, 1'b0, 32'h0);
        acc(1'b1, BASE - 32'h4, 32'hFFFF_FFFF, 1'b1, 32'h0);
        acc(1'b1, BASE + NP * 32'h4000, 32'hFFFF_FFFF, 1'b1, 32'h0);
        acc(1'b1, AIC - 32'h1000, 32'hFFFF_FFFF, 1'b1, 32'h0);
        acc(1'b0, AIC - 32'h3000, 32'h0, 1'b1, 32'h0);
        acc(1'b0, BASE + 32'h400C, 32'h0, 1'b1, 32'h0);
        acc(1'b0, BASE + 32'h4008, 32'h0, 1'b0, 32'h2);
        chk(vals[0 +: 32], 32'h1);
    endtask
    // reset in mid-run clears every stored value and the read data
    task automatic s_rereset;
        acc(1'b1, BASE + 32'h4000, 32'h0000_00F0, 1'b0, 32'h0);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        s_reset();
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        s_reset();
        acc(1'b0, BASE + 32'h4008, 32'h0, 1'b0, 32'h0);
    endtask
    initial begin
        rst_in = 1'b1;
        repeat (10) @(posedge clk_in);
        s_reset();
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        s_reset();
        s_set_clear();
        s_windows();
        s_refused();
        s_rereset();
        close_out();
    end
endmodule // psc_top_tb
